// ---- verilog/pxs_pkg.sv ----
// Constants, field layouts and register offsets of the pulsed proximity sensor control block.
// Assumes a single 20 MHz system clock and an Avalon-MM master on the register side.
// What this block does
// - After reset the sensor stays in shutdown and measures only once power-on and init are 1 and standby is 0.
// - Each measurement becomes a 12-bit unsigned count that the host can read.
// - The emitter current setting has eight levels from 50 mA to 156 mA and is applied during each pulse.
// - The pulse width is the multiplier (1T to 8T) times the base unit T chosen by a separate field.
// - The integration setting offers exactly four base durations.
// - In self-timed mode one pulse and measurement repeat at the programmed period of 10 ms to 80 ms.
// - The written offset count is subtracted from every raw count and only the difference is shown.
// - The close event is raised only after the threshold is exceeded for one more than the programmed number of measurements in a row.
// - The interrupt output is driven when a proximity change meets the programmed conditions.
// - With force mode on, power-on and init at 1 and standby off, each write of 1 to the trigger runs exactly one measurement.
// - In force mode without a pending trigger only the register interface is active.
package pxs_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int US_TICK_CYCLES = CLK_HZ / 1_000_000;
    localparam int DATA_W = 12;

    // Register byte offsets.
    localparam logic [4:0] OFS_CONF = 5'h00;
    localparam logic [4:0] OFS_MEAS = 5'h04;
    localparam logic [4:0] OFS_CONF3 = 5'h08;
    localparam logic [4:0] OFS_CANCEL = 5'h0c;
    localparam logic [4:0] OFS_THRESH = 5'h10;
    localparam logic [4:0] OFS_RESULT = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;
    localparam logic [4:0] OFS_MASK = 5'h1c;

    // Field positions.
    localparam int BIT_POWER_ON = 0;
    localparam int BIT_INIT = 1;
    localparam int BIT_STANDBY = 2;
    localparam int LSB_MULT = 0;
    localparam int LSB_BASE = 4;
    localparam int LSB_PERIOD = 8;
    localparam int LSB_CURRENT = 12;
    localparam int BIT_FORCE = 0;
    localparam int BIT_TRIGGER = 1;
    localparam int LSB_PERSIST = 16;
    localparam int BIT_ST_DONE = 0;
    localparam int BIT_ST_CLOSE = 1;
    localparam int BIT_ST_AWAY = 2;

    // Values after reset.
    localparam logic [2:0] RST_CONF = 3'h4;
    localparam logic [14:0] RST_MEAS = 15'h0000;
    localparam logic [11:0] RST_THRESH = 12'hfff;

    // Timing in microseconds; the cycle counts follow from the tick divider.
    localparam int BASE_UNIT_US = 50;
    localparam int PERIOD_MIN_MS = 10;
    localparam int US_PER_MS = 1000;
    localparam logic [16:0] PERIOD_MIN_US = 17'(PERIOD_MIN_MS * US_PER_MS);
endpackage

// ---- verilog/pxs_conv_rx.sv ----
// Serial receiver for the converter result word, clocked by sys_clk.
// Assumes the converter shifts the word MSB first on rising edges of conv_clk, which may stop between words.
`timescale 1ns/1ps
module pxs_conv_rx
    import pxs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic conv_clk,
    input wire logic conv_data,
    output logic done,
    output logic [DATA_W-1:0] data
);
    logic [1:0] clk_sync_q;
    logic [1:0] dat_sync_q;
    logic clk_prev_q;
    logic [3:0] bit_cnt_q;
    logic [DATA_W-1:0] shift_q;
    logic done_q;
    wire rise = clk_sync_q[1] & ~clk_prev_q;
    wire last_bit = (bit_cnt_q == 4'(DATA_W - 1));

    // Two flops on each pin; only the second stage feeds the edge finder.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clk_sync_q <= 2'h0;
            dat_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
        end else begin
            clk_sync_q <= {clk_sync_q[0], conv_clk};
            dat_sync_q <= {dat_sync_q[0], conv_data};
            clk_prev_q <= clk_sync_q[1];
        end
    end

    // Shift on each link clock rise; the count restarts whenever the receiver is idle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !enable) begin
            bit_cnt_q <= 4'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= rise & last_bit;
            if (rise) begin
                bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
            end
        end
    end

    // The data register keeps the last word so a partial frame never shows.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shift_q <= '0;
            data <= '0;
        end else if (enable && rise) begin
            shift_q <= {shift_q[DATA_W-2:0], dat_sync_q[1]};
            if (last_bit) begin
                data <= {shift_q[DATA_W-2:0], dat_sync_q[1]};
            end
        end
    end

    assign done = done_q;
endmodule

// ---- verilog/pxs_top.sv ----
// Proximity sensor control: register file, measurement sequencer, offset cancel and persistence interrupt.
// Assumes an Avalon-MM master on sys_clk and an external converter that returns its word over a serial link.
`timescale 1ns/1ps
module pxs_top
    import pxs_pkg::*;
#(
    parameter int TICK_CYCLES = US_TICK_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    output logic irq,
    output logic int_pin_o,
    output logic int_pin_oe,
    output logic emitter_on,
    output logic [2:0] emitter_current,
    output logic conv_request,
    input wire logic conv_clk,
    input wire logic conv_data
);
    typedef enum logic [2:0] {
        PXS_IDLE,
        PXS_PULSE,
        PXS_CONVERT,
        PXS_EVAL,
        PXS_WAIT
    } pxs_state_t;

    pxs_state_t state_q;
    logic [2:0] conf_q;
    logic [14:0] meas_q;
    logic force_q;
    logic trig_q;
    logic [11:0] cancel_q;
    logic [11:0] thresh_q;
    logic [1:0] persist_q;
    logic [11:0] result_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [4:0] tick_div_q;
    logic [16:0] width_cnt_q;
    logic [16:0] period_cnt_q;
    logic [2:0] hits_q;
    logic close_q;
    logic emitter_q;
    logic [2:0] ev_set;
    logic [DATA_W-1:0] raw_word;
    logic raw_done;

    // Register access: the request is answered one cycle after it is seen, on the edge where waitrequest is low.
    wire req = avs_read | avs_write;
    wire wr_en = avs_write & ack_q;
    wire lane0 = avs_byteenable[0];
    wire lane1 = avs_byteenable[1];
    wire lane2 = avs_byteenable[2];
    wire known = (avs_address == OFS_CONF) || (avs_address == OFS_MEAS) || (avs_address == OFS_CONF3)
        || (avs_address == OFS_CANCEL) || (avs_address == OFS_THRESH) || (avs_address == OFS_RESULT)
        || (avs_address == OFS_STATUS) || (avs_address == OFS_MASK);
    wire wr_conf = wr_en && (avs_address == OFS_CONF) && lane0;
    wire wr_meas = wr_en && (avs_address == OFS_MEAS);
    wire wr_conf3 = wr_en && (avs_address == OFS_CONF3) && lane0;
    wire wr_cancel = wr_en && (avs_address == OFS_CANCEL);
    wire wr_thresh = wr_en && (avs_address == OFS_THRESH);
    wire wr_status = wr_en && (avs_address == OFS_STATUS) && lane0;
    wire wr_mask = wr_en && (avs_address == OFS_MASK) && lane0;

    // Read selection; unmapped addresses read as zero and flag an error response.
    wire [31:0] rd_mux = (avs_address == OFS_CONF) ? {29'h0, conf_q} :
        (avs_address == OFS_MEAS) ? {17'h0, meas_q} :
        (avs_address == OFS_CONF3) ? {30'h0, trig_q, force_q} :
        (avs_address == OFS_CANCEL) ? {20'h0, cancel_q} :
        (avs_address == OFS_THRESH) ? {14'h0, persist_q, 4'h0, thresh_q} :
        (avs_address == OFS_RESULT) ? {20'h0, result_q} :
        (avs_address == OFS_STATUS) ? {29'h0, status_q} :
        (avs_address == OFS_MASK) ? {29'h0, mask_q} : 32'h0;

    // Setting fields decoded from the measurement register.
    wire [2:0] mult_sel = meas_q[LSB_MULT +: 3];
    wire [1:0] base_sel = meas_q[LSB_BASE +: 2];
    wire [1:0] period_sel = meas_q[LSB_PERIOD +: 2];

    // Base unit T is 50, 100, 150 or 200 us, four durations in all.
    // The select is widened before the add so the top code gives 200 us instead of wrapping to zero.
    wire [16:0] base_us = 17'(BASE_UNIT_US) * ({15'h0, base_sel} + 17'h1);
    // Pulse width is T times a multiplier of one to eight.
    wire [16:0] width_us = 17'(base_us * {14'h0, mult_sel} + base_us);
    // Period is 10, 20, 40 or 80 ms.
    wire [16:0] period_us = PERIOD_MIN_US << period_sel;

    // Power state and the two ways a measurement may begin.
    wire active = conf_q[BIT_POWER_ON] & conf_q[BIT_INIT] & ~conf_q[BIT_STANDBY];
    wire start_timed = active & ~force_q;
    wire start_forced = active & force_q & trig_q;
    wire us_tick = (tick_div_q == 5'(TICK_CYCLES - 1));
    wire width_done = us_tick && (width_cnt_q >= width_us - 17'h1);
    wire period_done = us_tick && (period_cnt_q >= period_us - 17'h1);

    // Offset cancel saturates at zero so a small raw count never wraps to a large one.
    wire [11:0] cancelled = (raw_word > cancel_q) ? raw_word - cancel_q : 12'h0;
    wire above = cancelled > thresh_q;
    wire [2:0] hits_next = (hits_q == 3'h7) ? hits_q : hits_q + 3'h1;
    wire persist_met = above && ({1'b0, persist_q} <= hits_q);

    // Events of one evaluation cycle.
    assign ev_set[BIT_ST_DONE] = (state_q == PXS_EVAL);
    assign ev_set[BIT_ST_CLOSE] = (state_q == PXS_EVAL) && persist_met && !close_q;
    assign ev_set[BIT_ST_AWAY] = (state_q == PXS_EVAL) && !above && close_q;

    // Microsecond tick from the system clock; every timer below counts in these ticks.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || us_tick) begin
            tick_div_q <= 5'h0;
        end else begin
            tick_div_q <= tick_div_q + 5'h1;
        end
    end

    // Bus handshake: one wait cycle, then the answer; read data are captured in the wait cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Configuration registers; standby is set after reset so the sensor starts in shutdown.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            conf_q <= RST_CONF;
            meas_q <= RST_MEAS;
            force_q <= 1'b0;
            cancel_q <= 12'h0;
            thresh_q <= RST_THRESH;
            persist_q <= 2'h0;
            mask_q <= 3'h0;
        end else begin
            if (wr_conf) begin
                conf_q <= avs_writedata[2:0];
            end
            if (wr_meas && lane0) begin
                meas_q[7:0] <= avs_writedata[7:0];
            end
            if (wr_meas && lane1) begin
                meas_q[14:8] <= avs_writedata[14:8];
            end
            if (wr_conf3) begin
                force_q <= avs_writedata[BIT_FORCE];
            end
            if (wr_cancel && lane0) begin
                cancel_q[7:0] <= avs_writedata[7:0];
            end
            if (wr_cancel && lane1) begin
                cancel_q[11:8] <= avs_writedata[11:8];
            end
            if (wr_thresh && lane0) begin
                thresh_q[7:0] <= avs_writedata[7:0];
            end
            if (wr_thresh && lane1) begin
                thresh_q[11:8] <= avs_writedata[11:8];
            end
            if (wr_thresh && lane2) begin
                persist_q <= avs_writedata[LSB_PERSIST +: 2];
            end
            if (wr_mask) begin
                mask_q <= avs_writedata[2:0];
            end
        end
    end

    // The trigger clears itself at the end of a forced run; a new write of 1 in that cycle still wins.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            trig_q <= 1'b0;
        end else if (wr_conf3 && avs_writedata[BIT_TRIGGER]) begin
            trig_q <= 1'b1;
        end else if (state_q == PXS_EVAL && force_q) begin
            trig_q <= 1'b0;
        end
    end

    // Sticky status: hardware setting wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_q <= 3'h0;
        end else begin
            status_q <= (status_q & ~(wr_status ? avs_writedata[2:0] : 3'h0)) | ev_set;
        end
    end

    // Measurement sequencer.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= PXS_IDLE;
        end else begin
            unique case (state_q)
                PXS_IDLE: begin
                    if (start_timed || start_forced) begin
                        state_q <= PXS_PULSE;
                    end
                end
                PXS_PULSE: begin
                    if (width_done) begin
                        state_q <= PXS_CONVERT;
                    end
                end
                PXS_CONVERT: begin
                    if (raw_done) begin
                        state_q <= PXS_EVAL;
                    end
                end
                PXS_EVAL: begin
                    state_q <= force_q ? PXS_IDLE : PXS_WAIT;
                end
                PXS_WAIT: begin
                    if (!start_timed) begin
                        state_q <= PXS_IDLE;
                    end else if (period_done) begin
                        state_q <= PXS_PULSE;
                    end
                end
            endcase
        end
    end

    // Pulse width and period timers; the period runs from the start of each pulse.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state_q == PXS_IDLE) begin
            width_cnt_q <= 17'h0;
            period_cnt_q <= 17'h0;
        end else if (us_tick) begin
            width_cnt_q <= (state_q == PXS_PULSE) ? width_cnt_q + 17'h1 : 17'h0;
            period_cnt_q <= period_done ? 17'h0 : period_cnt_q + 17'h1;
        end
    end

    // Emitter drive is registered so it cannot glitch on state decoding.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            emitter_q <= 1'b0;
        end else begin
            emitter_q <= (state_q == PXS_IDLE) ? (start_timed | start_forced) :
                (state_q == PXS_PULSE) ? !width_done :
                (state_q == PXS_WAIT) ? (start_timed & period_done) : 1'b0;
        end
    end

    // Result, persistence count and proximity state update once per measurement.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            result_q <= 12'h0;
            hits_q <= 3'h0;
            close_q <= 1'b0;
        end else if (state_q == PXS_EVAL) begin
            result_q <= cancelled;
            hits_q <= above ? hits_next : 3'h0;
            if (ev_set[BIT_ST_CLOSE]) begin
                close_q <= 1'b1;
            end else if (ev_set[BIT_ST_AWAY]) begin
                close_q <= 1'b0;
            end
        end
    end

    // Converter word arrives over the sampled serial link.
    pxs_conv_rx u_rx (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(state_q == PXS_CONVERT),
        .conv_clk(conv_clk),
        .conv_data(conv_data),
        .done(raw_done),
        .data(raw_word)
    );

    // Outputs; the interrupt pin is open drain and only ever pulls low.
    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata = rdata_q;
    assign avs_response_err = ack_q & ~known;
    assign irq = |(status_q & mask_q);
    assign int_pin_o = 1'b0;
    assign int_pin_oe = irq;
    assign emitter_on = emitter_q;
    assign emitter_current = meas_q[LSB_CURRENT +: 3];
    assign conv_request = (state_q == PXS_CONVERT);
endmodule

// ---- testbench/pxs_top_monitor.sv ----
// Concurrent checks on the top ports of the proximity control block.
// Assumes a bind from the bench top and the single sys_clk domain.
`timescale 1ns/1ps
module pxs_top_monitor #(
    parameter int TICK_CYCLES = 20
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic avs_response_err,
    input wire logic irq,
    input wire logic int_pin_o,
    input wire logic int_pin_oe,
    input wire logic emitter_on,
    input wire logic [2:0] emitter_current,
    input wire logic conv_request,
    input wire logic conv_clk,
    input wire logic conv_data
);
    localparam int MIN_LEN = 49 * TICK_CYCLES + 1;
    localparam int MAX_LEN = 1600 * TICK_CYCLES;
    logic [15:0] pulse_len_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Length of the running pulse, so its width can be bounded at the falling edge.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !emitter_on)
            pulse_len_q <= 16'h0000;
        else
            pulse_len_q <= pulse_len_q + 16'h0001;
    end
    a_irq_pin_match: assert property (int_pin_oe == irq)
        else $error("interrupt pin enable differs from irq");
    a_pin_pulls_low: assert property (int_pin_oe |-> !int_pin_o)
        else $error("interrupt pin driven high");
    a_reset_quiet: assert property ($past(sys_rst) |-> !emitter_on && !conv_request && !irq)
        else $error("activity right after reset");
    a_pulse_then_conv: assert property ($fell(emitter_on) |-> ##[0:2] conv_request)
        else $error("no conversion after pulse");
    a_no_overlap: assert property (!(emitter_on && conv_request))
        else $error("emitter on during conversion");
    a_pulse_width: assert property ($fell(emitter_on) |-> pulse_len_q >= MIN_LEN && pulse_len_q <= MAX_LEN)
        else $error("pulse width out of range");
    a_current_steady: assert property (emitter_on && $past(emitter_on) |-> $stable(emitter_current))
        else $error("emitter current changed within pulse");
    a_one_wait: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_err_in_answer: assert property (avs_response_err |-> !avs_waitrequest && (avs_read || avs_write))
        else $error("error flag outside answer cycle");
endmodule

// ---- testbench/pxs_conv_model.sv ----
// Behavioural converter that returns one result word over the serial link.
// Assumes the block raises conv_request once for each word it wants.
`timescale 1ns/1ps
module pxs_conv_model (
    input wire logic conv_request,
    input wire logic slow,
    input wire logic [11:0] word,
    output logic conv_clk,
    output logic conv_data
);
    int i;
    // Link clock stands low between frames; data flips after a frame so stale bits never look valid.
    initial begin
        conv_clk = 1'b0;
        conv_data = 1'b0;
    end
    always begin
        @(posedge conv_request);
        #(slow ? 20000 : 300);
        for (i = 11; i >= 0; i--) begin
            conv_data = word[i];
            #200 conv_clk = 1'b1;
            #200 conv_clk = 1'b0;
        end
        conv_data = ~conv_data;
    end
endmodule

// ---- testbench/test_pulsed_proximity_sensor_control.sv ----
// Self-checking bench of the proximity control block with a serial converter model.
// Assumes pxs_pkg and the design files are compiled first.
`timescale 1ns/1ps
module test_pulsed_proximity_sensor_control
    import pxs_pkg::*;
;
    localparam int TK = 2;
    int exp_us = 100;
    logic sys_clk;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, avs_response_err, irq, int_pin_o, int_pin_oe, emitter_on, conv_request;
    logic [2:0] emitter_current;
    logic conv_clk, conv_data;
    logic slow = 1'b0;
    logic [11:0] cw = 12'h000;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    pxs_top #(.TICK_CYCLES(TK)) pxs_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
        .irq(irq), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .emitter_on(emitter_on),
        .emitter_current(emitter_current), .conv_request(conv_request), .conv_clk(conv_clk), .conv_data(conv_data));
    pxs_conv_model pxs_conv_model_inst (.conv_request(conv_request), .slow(slow), .word(cw), .conv_clk(conv_clk),
        .conv_data(conv_data));
    // Clock and a free cycle count used to time pulses.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // The request stands until the rising edge at which waitrequest is sampled low; the answer is taken there.
    // Returning mid-cycle lets callers look at outputs after a write has settled; only the watchdog ends a wait.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        e = avs_response_err;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, q, e);
        chk(nm, q, exp);
    endtask
    task automatic pulse(output int t0, output int w);
        int n;
        n = 0;
        w = 0;
        while (emitter_on !== 1'b1 && n < 30000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        t0 = cyc;
        while (emitter_on === 1'b1 && w < 5000) begin
            @(posedge sys_clk);
            #1;
            w++;
        end
    endtask
    task automatic idle_chk(input int n);
        int k, hi;
        hi = 0;
        for (k = 0; k < n; k++) begin
            @(posedge sys_clk);
            #1;
            if (emitter_on !== 1'b0)
                hi++;
        end
        chk("emitter_idle", hi, 0);
    endtask
    // One forced measurement: trigger, pulse, conversion, self-clear and result.
    task automatic shot(input logic [11:0] word, input logic [11:0] exp);
        int t0, w, n;
        logic [31:0] q;
        logic e;
        cw = word;
        wr(OFS_CONF3, 32'h3);
        pulse(t0, w);
        chk("width_ok", w > (exp_us - 1) * TK && w <= exp_us * TK, 1);
        chk("current", emitter_current, 3'h5);
        n = 0;
        q = 32'h2;
        while (q[1] !== 1'b0 && n < 400) begin
            bus(1'b0, OFS_CONF3, 32'h0, q, e);
            n++;
        end
        chk("conf3", q, 32'h1);
        rdchk("result", OFS_RESULT, {20'h0, exp});
    endtask
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        rdchk("conf_rst", OFS_CONF, 32'h4);
        rdchk("thresh_rst", OFS_THRESH, 32'h00000fff);
        bus(1'b0, 5'h02, 32'h0, q, e);
        chk("unmapped_err", e, 1'b1);
        chk("unmapped_data", q, 32'h0);
        wr(OFS_CONF, 32'h7);
        idle_chk(600);
    endtask
    task automatic t_force;
        wr(OFS_MEAS, 32'h00005001);
        wr(OFS_CANCEL, 32'h010);
        wr(OFS_CONF3, 32'h1);
        wr(OFS_CONF, 32'h3);
        slow = 1'b1;
        shot(12'h123, 12'h113);
        slow = 1'b0;
        shot(12'h008, 12'h000);
        rdchk("done", OFS_STATUS, 32'h1);
        wr(OFS_STATUS, 32'h1);
        rdchk("cleared", OFS_STATUS, 32'h0);
        idle_chk(1000);
    endtask
    task automatic t_irq;
        wr(OFS_THRESH, 32'h00010100);
        wr(OFS_MASK, 32'h2);
        shot(12'h300, 12'h2f0);
        chk("irq_first", irq, 1'b0);
        shot(12'h300, 12'h2f0);
        chk("irq_second", {irq, int_pin_oe}, 2'h3);
        wr(OFS_MASK, 32'h0);
        chk("irq_masked", irq, 1'b0);
        wr(OFS_MASK, 32'h2);
        chk("irq_unmask", irq, 1'b1);
        wr(OFS_STATUS, 32'h7);
        chk("irq_clear", irq, 1'b0);
        wr(OFS_MEAS, 32'h00005030);
        exp_us = 200;
        shot(12'h050, 12'h040);
        rdchk("away", OFS_STATUS, 32'h5);
    endtask
    task automatic t_period;
        int t0, t1, w;
        wr(OFS_CONF3, 32'h0);
        pulse(t0, w);
        pulse(t1, w);
        chk("period_ok", t1 - t0 >= 20000 - TK && t1 - t0 <= 20000 + TK, 1);
        wr(OFS_CONF, 32'h7);
        wr(OFS_CONF, 32'h6);
        idle_chk(25000);
    endtask
    // Main sequence; the watchdog below ends a hung run through the same closing task.
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_force();
        t_irq();
        t_period();
        wrap_up();
    end
    initial begin
        #(90000 * 50);
        n_mismatch++;
        wrap_up();
    end
endmodule
bind pxs_top pxs_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) pxs_top_monitor_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err), .irq(irq), .int_pin_o(int_pin_o),
    .int_pin_oe(int_pin_oe), .emitter_on(emitter_on), .emitter_current(emitter_current),
    .conv_request(conv_request), .conv_clk(conv_clk), .conv_data(conv_data));
